//--- ppw_seq.sv
// Parallel port memory write sequencer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Run write cycles for external memory writes
// R2 - Two periods from latch end to strobe
// R3 - Address on bus around latch release
// R4 - Strobe low is duration minus flash extension
// R5 - Flash mode adds seven-period extension
// R6 - Software keeps duration nine or more in flash
// R7 - Optional one-period hold after strobe rise
// R8 - Data valid one period before strobe low
// R9 - Strobe recovery is flash plus hold plus one
// R10 - Hold interval before next latch strobe
// R11 - 8-bit: upper address high byte, data low
// R12 - 8-bit: four strobes per latch cycle
// R13 - 16-bit: one strobe if step nonzero
// R14 - 16-bit repeat strobes only when step is zero
// R15 - Latch strobe active high after reset; here polarity follows the ale_active_low input, which reset does not set
// R16 - Counts in peripheral clocks, two core clocks
// R17 - Phase state machine with down-counter
module ppw_seq (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Configuration
  input wire logic [4:0] strobe_duration_count,
  input wire logic flash_mode,
  input wire logic hold_cycle,
  input wire logic mode_16bit,
  input wire logic [1:0] address_step_setting,
  input wire logic ale_active_low,
  // Write requests
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Memory pins
  output logic [15:0] muxed_addr_data_bus_o,
  output logic [15:0] muxed_addr_data_bus_oe_n,
  output logic ale_o,
  output logic wr_n_o,
  // Status
  output logic busy
);
  // ********************************
  // Request buffer
  // ********************************
  logic q_valid;
  logic q_ready;
  logic [31:0] q_data;

  ppw_fifo #(.W(32), .DEPTH(ppw_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // ********************************
  // Peripheral clock tick
  // ********************************
  logic pdiv_q;
  logic tick;
  assign tick = ce && pdiv_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pdiv_q <= 1'b0;
    end else if (ce) begin
      pdiv_q <= ~pdiv_q; // R16
    end
  end

  // ********************************
  // Phase lengths
  // ********************************
  function automatic logic [5:0] strobe_len(input logic [4:0] dur, input logic fl);
    logic [5:0] ext;
    ext = fl ? ppw_pkg::FLASH_PCLK : 6'h00; // R5
    strobe_len = ({1'b0, dur} > ext) ? ({1'b0, dur} - ext) : 6'h01; // R4 R6
  endfunction

  function automatic logic [15:0] bus_word(input logic m16, input logic [15:0] a,
                                           input logic [15:0] d);
    bus_word = m16 ? d : {a[15:8], d[7:0]}; // R11
  endfunction

  logic [5:0] hold_len;
  logic [5:0] recov_len;
  assign hold_len = hold_cycle ? ppw_pkg::HOLD_PCLK : 6'h00; // R7
  // Rise to next fall: F + H + 1, hold phase supplies H
  assign recov_len = (flash_mode ? ppw_pkg::FLASH_PCLK : 6'h00)
                     + ppw_pkg::RECOV_PCLK; // R9

  // ********************************
  // Sequencer
  // ********************************
  ppw_pkg::ppw_state_t st_q;
  logic [5:0] cnt_q;
  logic [2:0] left_q;
  logic [15:0] addr_q;
  logic [15:0] data_q;
  logic ale_act_q;
  logic wr_act_q;
  logic more_q;
  logic last_done;
  logic more;
  logic multi;
  logic start;
  logic enter_recov;

  assign busy = (st_q != ppw_pkg::PPW_IDLE);
  assign last_done = (cnt_q <= 6'h01);
  // 8-bit groups of four; 16-bit bursts only with zero step
  assign multi = !mode_16bit || (address_step_setting == 2'h0); // R12 R13
  // Decided on entry to recovery, so the next word can lead its strobe
  assign more = !mode_16bit ? (left_q != 3'h0)
                : (multi && q_valid && (q_data[31:16] == addr_q)); // R13 R14
  assign start = tick && (st_q == ppw_pkg::PPW_IDLE) && q_valid; // R1
  assign enter_recov = tick && last_done && (((st_q == ppw_pkg::PPW_STROBE)
                       && (hold_len == 6'h00)) || (st_q == ppw_pkg::PPW_HOLD));
  assign q_ready = start || (enter_recov && mode_16bit && more);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      more_q <= 1'b0;
    end else if (start) begin
      more_q <= 1'b0;
    end else if (enter_recov) begin
      more_q <= more; // R13 R14
    end
  end

  // ********************************
  // Address and data words
  // ********************************
  // Loaded once the old strobe's hold is over, never during it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      left_q <= 3'h0;
    end else if (start) begin
      addr_q <= q_data[31:16];
      data_q <= q_data[15:0];
      left_q <= ppw_pkg::GROUP8 - 3'h1;
    end else if (enter_recov && more) begin
      if (!mode_16bit) begin
        // Head word stays queued; only its low byte is borrowed
        left_q <= left_q - 3'h1;
        addr_q <= addr_q + 16'h0001;
        data_q <= q_valid ? {8'h00, q_data[7:0]} : 16'h0000;
      end else begin
        data_q <= q_data[15:0];
      end
    end
  end

  // ********************************
  // Phase state machine
  // ********************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ppw_pkg::PPW_IDLE;
      cnt_q <= 6'h00;
    end else if (tick) begin
      unique case (st_q)
        ppw_pkg::PPW_IDLE: begin
          if (q_valid) begin // R1
            cnt_q <= ppw_pkg::LATCH_PCLK;
            st_q <= ppw_pkg::PPW_LATCH; // R17
          end
        end
        ppw_pkg::PPW_LATCH: begin
          cnt_q <= cnt_q - 6'h01;
          if (last_done) begin
            cnt_q <= ppw_pkg::ALE_GAP_PCLK; // R2
            st_q <= ppw_pkg::PPW_GAP;
          end
        end
        ppw_pkg::PPW_GAP: begin
          cnt_q <= cnt_q - 6'h01;
          if (last_done) begin
            cnt_q <= strobe_len(strobe_duration_count, flash_mode);
            st_q <= ppw_pkg::PPW_STROBE;
          end
        end
        ppw_pkg::PPW_STROBE: begin
          cnt_q <= cnt_q - 6'h01;
          if (last_done) begin
            if (hold_len != 6'h00) begin
              cnt_q <= hold_len;
              st_q <= ppw_pkg::PPW_HOLD;
            end else begin
              cnt_q <= recov_len;
              st_q <= ppw_pkg::PPW_RECOV;
            end
          end
        end
        ppw_pkg::PPW_HOLD: begin
          cnt_q <= cnt_q - 6'h01;
          if (last_done) begin
            cnt_q <= recov_len;
            st_q <= ppw_pkg::PPW_RECOV;
          end
        end
        ppw_pkg::PPW_RECOV: begin
          cnt_q <= cnt_q - 6'h01;
          if (last_done) begin
            if (more_q) begin
              // Next strobe in the same latch cycle
              cnt_q <= strobe_len(strobe_duration_count, flash_mode);
              st_q <= ppw_pkg::PPW_STROBE; // R12
            end else begin
              st_q <= ppw_pkg::PPW_IDLE; // R10
            end
          end
        end
        default: begin
          st_q <= ppw_pkg::PPW_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // Pin drivers
  // ********************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ale_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else if (ce) begin
      ale_act_q <= (st_q == ppw_pkg::PPW_LATCH);
      wr_act_q <= (st_q == ppw_pkg::PPW_STROBE); // R4
    end
  end

  assign ale_o = ale_act_q ^ ale_active_low; // R15
  assign wr_n_o = ~wr_act_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      muxed_addr_data_bus_o <= 16'h0000;
      muxed_addr_data_bus_oe_n <= 16'hffff;
    end else if (ce) begin
      unique case (st_q)
        ppw_pkg::PPW_LATCH: begin
          muxed_addr_data_bus_o <= addr_q; // R3
          muxed_addr_data_bus_oe_n <= 16'h0000;
        end
        ppw_pkg::PPW_GAP: begin
          // First gap period keeps the address up for the external latch
          if (cnt_q == ppw_pkg::ALE_GAP_PCLK) begin
            muxed_addr_data_bus_o <= addr_q; // R3
          end else begin
            muxed_addr_data_bus_o <= bus_word(mode_16bit, addr_q, data_q); // R8 R11
          end
          muxed_addr_data_bus_oe_n <= 16'h0000;
        end
        ppw_pkg::PPW_STROBE, ppw_pkg::PPW_HOLD: begin
          muxed_addr_data_bus_o <= bus_word(mode_16bit, addr_q, data_q); // R8 R11
          muxed_addr_data_bus_oe_n <= 16'h0000; // R7
        end
        ppw_pkg::PPW_RECOV: begin
          // Next word leads its strobe by the whole recovery
          if (more_q) begin
            muxed_addr_data_bus_o <= bus_word(mode_16bit, addr_q, data_q); // R8
            muxed_addr_data_bus_oe_n <= 16'h0000;
          end else begin
            // Bus released between groups
            muxed_addr_data_bus_o <= 16'h0000;
            muxed_addr_data_bus_oe_n <= 16'hffff;
          end
        end
        default: begin
          muxed_addr_data_bus_o <= 16'h0000;
          muxed_addr_data_bus_oe_n <= 16'hffff;
        end
      endcase
    end
  end
endmodule

// ********************************
// Request FIFO
// ********************************
module ppw_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  // One bit wider so full and empty differ
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- ppw_pkg.sv
// Package: constants and types for the parallel port write sequencer
package ppw_pkg;
  // Peripheral clock period in core clocks
  localparam int unsigned PCLK_DIV = 2;
  // Phase lengths in peripheral clock periods
  localparam logic [5:0] LATCH_PCLK = 6'h02;
  localparam logic [5:0] ALE_GAP_PCLK = 6'h02;
  localparam logic [5:0] FLASH_PCLK = 6'h07;
  localparam logic [5:0] HOLD_PCLK = 6'h01;
  localparam logic [5:0] RECOV_PCLK = 6'h01;
  // Strobes per latch cycle in 8-bit mode
  localparam logic [2:0] GROUP8 = 3'h4;
  // Reset values and FIFO depth
  localparam logic ALE_POL_RST = 1'b1;
  localparam logic [4:0] DUR_RST = 5'h09;
  localparam int unsigned FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    PPW_IDLE = 3'b000,
    PPW_LATCH = 3'b001,
    PPW_GAP = 3'b011,
    PPW_STROBE = 3'b010,
    PPW_HOLD = 3'b110,
    PPW_RECOV = 3'b111
  } ppw_state_t;
endpackage

//--- ppw_fifo.sv
// The request FIFO module sits with the sequencer in ppw_seq.sv

//--- ppw_seq_asserts.sv
// Pin timing checker for the write sequencer
`timescale 1ns/1ps
`default_nettype none
module ppw_seq_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire logic [4:0] strobe_duration_count,
  input wire logic flash_mode,
  input wire logic hold_cycle,
  input wire logic ale_active_low,
  // Pins
  input wire logic [15:0] muxed_addr_data_bus_o,
  input wire logic [15:0] muxed_addr_data_bus_oe_n,
  input wire logic ale_o,
  input wire logic wr_n_o,
  input wire logic busy
);
  // ****
  // Helpers
  // ****
  logic [6:0] low_q, high_q, f_v, d_v, exp_low, exp_rec;
  logic ale_act;
  assign ale_act = ale_o ^ ale_active_low;
  assign f_v = flash_mode ? 7'h07 : 7'h00;
  assign d_v = {2'h0, strobe_duration_count};
  // Short durations clamp to one period
  assign exp_low = (d_v > f_v) ? (d_v - f_v) << 1 : 7'h02;
  assign exp_rec = (f_v + {6'h00, hold_cycle} + 7'h01) << 1;
  always_ff @(posedge clk) begin
    if (!nrst || wr_n_o) low_q <= 7'h00;
    else low_q <= low_q + 7'h01;
  end
  // Saturates so long idle spans stay large
  always_ff @(posedge clk) begin
    if (!nrst) high_q <= 7'h7f;
    else if (!wr_n_o) high_q <= 7'h00;
    else if (high_q != 7'h7f) high_q <= high_q + 7'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****
  // Properties
  // ****
  ale_width_a: assert property ($rose(ale_act) |-> ale_act [*4] ##1 !ale_act)
    else $error("latch strobe width wrong");
  latch_gap_a: assert property ($fell(ale_act) |-> wr_n_o [*4])
    else $error("write strobe too soon after latch");
  strobe_len_a: assert property ($rose(wr_n_o) && $past(nrst) |-> low_q == exp_low)
    else $error("write strobe low time wrong");
  strobe_recov_a: assert property ($fell(wr_n_o) |-> high_q >= exp_rec)
    else $error("strobe recovery too short");
  data_stable_a: assert property (!wr_n_o |->
    $stable(muxed_addr_data_bus_o) && $past(muxed_addr_data_bus_o, 2) == muxed_addr_data_bus_o)
    else $error("bus moved near strobe");
  hold_stable_a: assert property ($rose(wr_n_o) && hold_cycle |->
    $stable(muxed_addr_data_bus_o) [*2])
    else $error("bus moved during hold");
  latch_after_a: assert property ($rose(ale_act) |-> high_q > {5'h00, hold_cycle, 1'b0})
    else $error("latch too soon after strobe");
  addr_drive_a: assert property (ale_act |-> busy && muxed_addr_data_bus_oe_n == 16'h0000)
    else $error("address not driven in latch");
  reset_idle_a: assert property (disable iff (1'b0) !nrst |=> ale_o == ale_active_low
    && wr_n_o && !busy && muxed_addr_data_bus_oe_n == 16'hffff)
    else $error("pins not idle after reset");
  cover property (flash_mode && $rose(wr_n_o));
  cover property (hold_cycle && $rose(wr_n_o));
  cover property ($fell(ale_act));
endmodule
bind ppw_seq ppw_seq_asserts chk (.clk(clk), .nrst(nrst),
  .strobe_duration_count(strobe_duration_count), .flash_mode(flash_mode),
  .hold_cycle(hold_cycle), .ale_active_low(ale_active_low),
  .muxed_addr_data_bus_o(muxed_addr_data_bus_o),
  .muxed_addr_data_bus_oe_n(muxed_addr_data_bus_oe_n), .ale_o(ale_o), .wr_n_o(wr_n_o),
  .busy(busy));
`default_nettype wire

//--- ppw_mem_model.sv
// External latch and memory model
`timescale 1ns/1ps
`default_nettype none
module ppw_mem_model (
  // Clock and setup
  input wire logic clk,
  input wire logic mode_16bit,
  input wire logic ale_active_low,
  // Pins
  input wire logic [15:0] bus,
  input wire logic ale_o,
  input wire logic wr_n_o,
  // Readback
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  output int n_ale,
  output int n_wr
);
  logic [15:0] mem [0:255];
  logic [15:0] lat_q, dat_q;
  logic [7:0] idx_q;
  logic ale_q = 1'b0;
  logic wr_q = 1'b1;
  assign rd_data = mem[rd_addr];
  initial begin
    n_ale = 0;
    n_wr = 0;
  end
  // Sampled on clk since pins are registered
  always @(posedge clk) begin
    ale_q <= ale_o ^ ale_active_low;
    wr_q <= wr_n_o;
    if (ale_q && !(ale_o ^ ale_active_low)) begin
      lat_q <= bus;
      idx_q <= 8'h00;
      n_ale <= n_ale + 1;
    end
    if (!wr_n_o) dat_q <= bus;
    if (!wr_q && wr_n_o) begin
      mem[lat_q[7:0] + (mode_16bit ? 8'h00 : idx_q)] <= dat_q;
      idx_q <= idx_q + 8'h01;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Testbench for the write sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, nrst, ce, flash_mode, hold_cycle, mode_16bit, ale_active_low, wr_valid;
  logic ale_o, wr_n_o, busy, wr_ready;
  logic [4:0] strobe_duration_count;
  logic [1:0] address_step_setting;
  logic [15:0] wr_addr, wr_data, bus, oe_n, rd_data;
  logic [7:0] rd_addr;
  int n_errors = 0, compares = 0, cyc = 0, n_ale, n_wr, a0, w0;
  ppw_seq dut (.clk(clk), .nrst(nrst), .ce(ce), .strobe_duration_count(strobe_duration_count),
    .flash_mode(flash_mode), .hold_cycle(hold_cycle), .mode_16bit(mode_16bit),
    .address_step_setting(address_step_setting), .ale_active_low(ale_active_low),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .muxed_addr_data_bus_o(bus), .muxed_addr_data_bus_oe_n(oe_n), .ale_o(ale_o),
    .wr_n_o(wr_n_o), .busy(busy));
  ppw_mem_model mem (.clk(clk), .mode_16bit(mode_16bit), .ale_active_low(ale_active_low),
    .bus(bus), .ale_o(ale_o), .wr_n_o(wr_n_o), .rd_addr(rd_addr), .rd_data(rd_data),
    .n_ale(n_ale), .n_wr(n_wr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Packed as flash, hold, 16-bit, step, low polarity
  task automatic cfg(input logic [4:0] d, input logic [5:0] b);
    @(posedge clk);
    strobe_duration_count <= d;
    {flash_mode, hold_cycle, mode_16bit, address_step_setting, ale_active_low} <= b;
    a0 = n_ale;
    w0 = n_wr;
  endtask
  // Valid stays up so requests can go back to back
  task automatic push(input logic [15:0] a, input logic [15:0] d);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    do @(negedge clk); while (wr_ready !== 1'b1);
    @(posedge clk);
  endtask
  task automatic settle(input int na, input int nw);
    int q;
    q = 0;
    if (wr_valid) wr_valid <= 1'b0;
    while (q < 8) begin
      @(negedge clk);
      q = busy === 1'b0 ? q + 1 : 0;
    end
    check(n_ale - a0, na);
    check(n_wr - w0, nw);
    check(busy, 1'b0);
    check(oe_n, 16'hffff);
  endtask
  task automatic mchk(input logic [7:0] a, input logic [15:0] e);
    rd_addr = a;
    #1;
    check(rd_data, e);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ****
  // Sequence
  // ****
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    wr_valid = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    strobe_duration_count = 5'h09;
    {flash_mode, hold_cycle, mode_16bit, address_step_setting, ale_active_low} = 6'h00;
    rd_addr = 8'h00;
    repeat (2) @(posedge clk);
    #1 check(ale_o, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    cfg(5'h03, 6'b001010);
    push(16'h0010, 16'haaaa);
    push(16'h0011, 16'h5555);
    settle(2, 2);
    mchk(8'h10, 16'haaaa);
    mchk(8'h11, 16'h5555);
    cfg(5'h03, 6'b011000);
    push(16'h0030, 16'h1111);
    push(16'h0030, 16'h2222);
    settle(1, 2);
    mchk(8'h30, 16'h2222);
    cfg(5'h03, 6'b000010);
    push(16'h1220, 16'h0034);
    settle(1, 4);
    mchk(8'h20, 16'h1234);
    cfg(5'h09, 6'b111011);
    push(16'h0040, 16'hbeef);
    settle(1, 1);
    mchk(8'h40, 16'hbeef);
    check(ale_o, 1'b1);
    cfg(5'h1f, 6'b001010);
    for (int i = 0; i < 5; i++) push(16'h0050 + 16'(i), 16'hc000 + 16'(i));
    wr_valid <= 1'b0;
    @(negedge clk);
    check(wr_ready, 1'b0);
    settle(5, 5);
    mchk(8'h54, 16'hc004);
    cfg(5'h03, 6'b001010);
    ce <= 1'b0;
    push(16'h0060, 16'h6666);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(busy, 1'b0);
    check(wr_ready, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    settle(1, 1);
    mchk(8'h60, 16'h6666);
    tally_and_finish;
  end
endmodule
`default_nettype wire
